// [hdl/tsc_slave.sv]
// tuner end of the two-wire control port: register writes and status reads
`timescale 1ns/1ns
`default_nettype none
module tsc_slave (
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    tsc_if.device                         bus,
    input  wire logic                     auto_band_select,
    input  wire logic [tsc_pkg::OSC_W-1:0]  manual_oscillator,
    input  wire logic [tsc_pkg::SUB_W-1:0]  manual_subband,
    input  wire logic [tsc_pkg::OSC_W-1:0]  auto_oscillator,
    input  wire logic [tsc_pkg::SUB_W-1:0]  auto_subband,
    input  wire logic [tsc_pkg::TUNE_W-1:0] tuning_voltage,
    input  wire logic [7:0]               status_byte1_in,
    output logic                          wr_valid,
    output logic [7:0]                    wr_addr,
    output logic [7:0]                    wr_data,
    output logic                          power_cycled_flag
);
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_reg  = 3'b010,
        st_data = 3'b011,
        st_read = 3'b100
    } slave_state_e;

    slave_state_e state;
    logic [3:0]   bit_cnt;
    logic [7:0]   shreg;
    logic [7:0]   tx_hold;
    logic [7:0]   reg_ptr;
    logic         ack_pending;
    logic         read_dir;
    logic         byte_sel;
    logic         read_seen;
    logic         sda_oe;
    logic         scl_meta;
    logic         scl_sync;
    logic         scl_prev;
    logic         sda_meta;
    logic         sda_sync;
    logic         sda_prev;

    // both lines pass two flops; edges are found on the second stage only
    always_ff @(posedge clk_sys) begin
        scl_meta <= bus.scl;
        scl_sync <= scl_meta;
        scl_prev <= scl_sync;
        sda_meta <= bus.sda;
        sda_sync <= sda_meta;
        sda_prev <= sda_sync;
    end

    // bus events; equal synchroniser depth keeps sda and scl aligned
    wire scl_rise   = scl_sync && !scl_prev;
    wire scl_fall   = !scl_sync && scl_prev;
    wire start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
    wire stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync;
    wire active     = (state != st_idle);
    wire data_rise  = scl_rise && active && (bit_cnt == tsc_pkg::LAST_DATA_BIT);
    wire ack_rise   = scl_rise && active && (bit_cnt == tsc_pkg::ACK_SLOT);
    wire [7:0] byte_in = {shreg[6:0], sda_sync};
    wire addr_match = (byte_in[7:1] == tsc_pkg::SLAVE_ADDR);
    wire master_ack = !sda_sync;

    // status bytes: the oscillator fields follow whichever source is in charge
    wire [tsc_pkg::OSC_W-1:0] selected_oscillator =
        auto_band_select ? auto_oscillator : manual_oscillator;
    wire [tsc_pkg::SUB_W-1:0] oscillator_subband =
        auto_band_select ? auto_subband : manual_subband;
    wire [7:0] oscillator_band_tune_status =
        {selected_oscillator, oscillator_subband, tuning_voltage};
    wire [7:0] status_byte1 = (status_byte1_in & ~tsc_pkg::PWR_MASK)
                            | (power_cycled_flag ? tsc_pkg::PWR_MASK : 8'h00);
    // only the two status bytes can ever be put on the line
    wire [7:0] tx_byte = byte_sel ? oscillator_band_tune_status : status_byte1;
    wire       tx_bit  = (bit_cnt == 4'h0) ? tx_byte[7] : tx_hold[~bit_cnt[2:0]];

    // bit counter and receive shifter; counting restarts at every start
    always_ff @(posedge clk_sys) begin
        if (reset || start_seen) begin
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
        end else if (scl_rise && active) begin
            shreg   <= byte_in;
            bit_cnt <= (bit_cnt == tsc_pkg::ACK_SLOT) ? 4'h0 : bit_cnt + 4'h1;
        end
    end

    // transaction state; a stop always returns to idle, and only a stop or a new start ends a write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state       <= st_idle;
            ack_pending <= 1'b0;
            read_dir    <= 1'b0;
            byte_sel    <= 1'b0;
        end else if (start_seen) begin
            state       <= st_addr;
            ack_pending <= 1'b0;
        end else if (stop_seen) begin
            state       <= st_idle;
            ack_pending <= 1'b0;
        end else if (data_rise) begin
            case (state)
                st_addr: begin
                    ack_pending <= addr_match;
                    read_dir    <= (byte_in[0] == tsc_pkg::RW_READ);
                end
                st_reg:  ack_pending <= 1'b1;
                st_data: ack_pending <= 1'b1;
                default: ack_pending <= 1'b0;
            endcase
        end else if (ack_rise) begin
            case (state)
                st_addr: begin
                    byte_sel <= 1'b0;
                    if (!ack_pending) begin
                        state <= st_idle;
                    end else if (read_dir) begin
                        state <= st_read;
                    end else begin
                        state <= st_reg;
                    end
                end
                st_reg:  state <= st_data;
                st_data: state <= st_data;
                st_read: begin
                    // an ack past byte two wraps to byte one; a nack lets go of the bus
                    if (master_ack) begin
                        byte_sel <= !byte_sel;
                    end else begin
                        state <= st_idle;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // register pointer and write strobe; pointer steps after every stored byte
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_ptr  <= 8'h00;
            wr_valid <= 1'b0;
            wr_addr  <= 8'h00;
            wr_data  <= 8'h00;
        end else begin
            wr_valid <= 1'b0;
            if (data_rise && !start_seen && !stop_seen && state == st_reg) begin
                reg_ptr <= byte_in;
            end else if (data_rise && !start_seen && !stop_seen && state == st_data) begin
                wr_valid <= 1'b1;
                wr_addr  <= reg_ptr;
                wr_data  <= byte_in;
                reg_ptr  <= reg_ptr + 8'h01;
            end
        end
    end

    // sda driver: changes only after scl falls, so data never moves while scl is high
    always_ff @(posedge clk_sys) begin
        if (reset || start_seen || stop_seen) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            if (bit_cnt == tsc_pkg::ACK_SLOT && state != st_read) begin
                sda_oe <= ack_pending;
            end else if (bit_cnt == tsc_pkg::ACK_SLOT) begin
                sda_oe <= 1'b0;
            end else if (state == st_read) begin
                sda_oe <= !tx_bit;
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // snapshot of the outgoing byte so a mid-byte status change cannot tear it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_hold <= 8'h00;
        end else if (scl_fall && state == st_read && bit_cnt == 4'h0) begin
            tx_hold <= tx_byte;
        end
    end

    // power flag: set by reset, cleared by the stop that closes a read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            read_seen         <= 1'b0;
            power_cycled_flag <= tsc_pkg::POWER_FLAG_INIT;
        end else if (start_seen) begin
            read_seen <= 1'b0;
        end else if (stop_seen) begin
            read_seen <= 1'b0;
            if (read_seen) begin
                power_cycled_flag <= 1'b0;
            end
        end else if (ack_rise && state == st_addr && ack_pending && read_dir) begin
            read_seen <= 1'b1;
        end
    end

    // open drain: the pin only ever pulls low
    assign bus.s_sda_o  = 1'b0;
    assign bus.s_sda_oe = sda_oe;
endmodule
`default_nettype wire

// [hdl/tsc_pkg.sv]
// constants shared by both ends of the tuner two-wire control port
// Overview of operation
// - status byte two bits 7:6 report oscillator
// - status byte two bits 5:3 report subband
// - status byte two bits 2:0 report tuning voltage
// - master clocks the bus up to 400kHz
// - eight data bits plus one ack bit
// - sda stable while scl high
// - start and stop are sda edges, scl high
// - ack means sda low through ninth high
// - nack means sda released through ninth high
// - master retries later after a nack (tsc_master here only sets nack_error and sends a stop, with no retry)
// - address 1100000 then direction bit
// - slave watches start, acks matching address
// - write acks address then register pointer
// - data msb first, stored then acked
// - further write bytes go to next register
// - write lasts until stop
// - only two status bytes are readable
// - read sends byte one, then byte two
// - master acks or nacks, then stops
// - both lines released while bus idle
// - stop ending a read clears power flag
package tsc_pkg;
    localparam logic [6:0] SLAVE_ADDR      = 7'h60;
    localparam logic       RW_READ         = 1'h1;
    localparam logic [3:0] ACK_SLOT        = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT   = 4'h7;
    localparam int         OSC_W           = 2;
    localparam int         SUB_W           = 3;
    localparam int         TUNE_W          = 3;
    localparam logic [7:0] PWR_MASK        = 8'h04;
    localparam logic       POWER_FLAG_INIT = 1'h1;
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         SCL_PERIOD_NS   = 2500;
    localparam int         QUARTER_CYCLES  = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam logic [1:0] Q_LOW           = 2'h0;
    localparam logic [1:0] Q_DATA          = 2'h1;
    localparam logic [1:0] Q_RISE          = 2'h2;
    localparam logic [1:0] Q_SAMPLE        = 2'h3;
endpackage

// [hdl/tsc_if.sv]
// open-drain two-wire bus joining the master end and the tuner end
`timescale 1ns/1ns
`default_nettype none
interface tsc_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-ups: a line is low only while someone drives a zero
    assign scl = !(m_scl_oe && !m_scl_o);
    assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);

    modport device (
        input  scl,
        input  sda,
        output s_sda_o,
        output s_sda_oe
    );
    modport host (
        input  scl,
        input  sda,
        output m_scl_o,
        output m_scl_oe,
        output m_sda_o,
        output m_sda_oe
    );
endinterface
`default_nettype wire

// [hdl/tsc_master.sv]
// bus master end of the two-wire control port: writes bursts, reads status
`timescale 1ns/1ns
`default_nettype none
module tsc_master #(
    parameter int QUARTER = tsc_pkg::QUARTER_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    tsc_if.host             bus,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_reg,
    input  wire logic [3:0] cmd_count,
    input  wire logic [7:0] wr_byte,
    output logic            cmd_ready,
    output logic            wr_take,
    output logic            rd_valid,
    output logic [7:0]      rd_byte,
    output logic            done,
    output logic            nack_error
);
    typedef enum logic [1:0] {
        m_idle  = 2'b00,
        m_start = 2'b01,
        m_bit   = 2'b10,
        m_stop  = 2'b11
    } master_state_e;

    master_state_e state;
    logic [7:0]    div_cnt;
    logic          tick;
    logic [1:0]    q;
    logic [3:0]    bit_idx;
    logic [4:0]    byte_idx;
    logic [7:0]    shift;
    logic          rd_mode;
    logic [7:0]    reg_l;
    logic [3:0]    count_l;
    logic          scl_oe;
    logic          sda_oe;
    logic          sda_meta;
    logic          sda_sync;

    // quarter-bit enable; a whole bit lasts four of them, keeping scl at or below 400kHz
    always_ff @(posedge clk_sys) begin
        if (reset || div_cnt == 8'(QUARTER - 1)) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    always_ff @(posedge clk_sys) begin
        tick <= !reset && (div_cnt == 8'(QUARTER - 1));
    end

    // returning sda is an outside level: two flops before use
    always_ff @(posedge clk_sys) begin
        sda_meta <= bus.sda;
        sda_sync <= sda_meta;
    end

    // byte bookkeeping
    wire       sending   = (byte_idx == 5'h00) || !rd_mode;
    wire [4:0] last_idx  = rd_mode ? {1'b0, count_l} : {1'b0, count_l} + 5'h01;
    wire       last_byte = (byte_idx == last_idx);
    wire [7:0] next_tx   = (byte_idx == 5'h00) ? reg_l : wr_byte;
    wire       in_ack    = (bit_idx == tsc_pkg::ACK_SLOT);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= m_idle;
            q <= tsc_pkg::Q_LOW;
            bit_idx <= 4'h0;
            byte_idx <= 5'h00;
            shift <= 8'h00;
            rd_mode <= 1'b0;
            reg_l <= 8'h00;
            count_l <= 4'h0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            cmd_ready <= 1'b1;
            wr_take <= 1'b0;
            rd_valid <= 1'b0;
            rd_byte <= 8'h00;
            done <= 1'b0;
            nack_error <= 1'b0;
        end else begin
            wr_take  <= 1'b0;
            rd_valid <= 1'b0;
            done     <= 1'b0;
            case (state)
                m_idle: begin
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready  <= 1'b0;
                        rd_mode    <= cmd_read;
                        reg_l      <= cmd_reg;
                        count_l    <= cmd_count;
                        nack_error <= 1'b0;
                        q          <= tsc_pkg::Q_LOW;
                        state      <= m_start;
                    end
                end
                m_start: if (tick) begin
                    if (q == tsc_pkg::Q_LOW) begin
                        sda_oe <= 1'b1;
                        q      <= tsc_pkg::Q_DATA;
                    end else begin
                        scl_oe   <= 1'b1;
                        bit_idx  <= 4'h0;
                        byte_idx <= 5'h00;
                        shift    <= {tsc_pkg::SLAVE_ADDR, rd_mode};
                        state    <= m_bit;
                    end
                end
                m_bit: if (tick) begin
                    q <= q + 2'h1;
                    case (q)
                        tsc_pkg::Q_LOW:  scl_oe <= 1'b1;
                        // sda moves only while scl is low
                        tsc_pkg::Q_DATA: begin
                            if (!in_ack) begin
                                sda_oe <= sending && !shift[7];
                            end else begin
                                sda_oe <= !sending && !last_byte;
                            end
                        end
                        tsc_pkg::Q_RISE: scl_oe <= 1'b0;
                        default: begin
                            if (!in_ack) begin
                                shift   <= {shift[6:0], sda_sync};
                                bit_idx <= bit_idx + 4'h1;
                            end else if (sending && sda_sync) begin
                                nack_error <= 1'b1;
                                state      <= m_stop;
                            end else begin
                                rd_valid <= !sending;
                                rd_byte  <= shift;
                                wr_take  <= !rd_mode && (byte_idx > 5'h00);
                                bit_idx  <= 4'h0;
                                byte_idx <= byte_idx + 5'h01;
                                shift    <= next_tx;
                                if (last_byte) begin
                                    state <= m_stop;
                                end
                            end
                        end
                    endcase
                end
                m_stop: if (tick) begin
                    q <= q + 2'h1;
                    case (q)
                        tsc_pkg::Q_LOW:  scl_oe <= 1'b1;
                        tsc_pkg::Q_DATA: sda_oe <= 1'b1;
                        tsc_pkg::Q_RISE: scl_oe <= 1'b0;
                        default: begin
                            sda_oe    <= 1'b0;
                            done      <= 1'b1;
                            cmd_ready <= 1'b1;
                            state     <= m_idle;
                        end
                    endcase
                end
                default: state <= m_idle;
            endcase
        end
    end

    assign bus.m_scl_o  = 1'b0;
    assign bus.m_scl_oe = scl_oe;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_sda_oe = sda_oe;
endmodule
`default_nettype wire

// [test/tsc_asserts.sv]
// concurrent checks on the two-wire bus joining the master end and the tuner end
`timescale 1ns/1ns
`default_nettype none
module tsc_asserts (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_sda_oe,
    input wire logic s_sda_oe
);
    logic       prev_scl;
    logic       prev_sda;
    logic       busy;
    logic       rw;
    logic       matched;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] shift;
    wire        start_seen = scl && prev_scl && prev_sda && !sda;
    wire        stop_seen  = scl && prev_scl && !prev_sda && sda;
    wire        scl_rise   = scl && !prev_scl;
    wire        ack_rise   = scl_rise && bit_cnt == 4'h8;

    // tracker of frame, bit slot and address byte; byte index saturates so long bursts stay cheap
    always_ff @(posedge clk_sys) begin
        prev_scl <= reset | scl;
        prev_sda <= reset | sda;
        busy     <= !reset && (start_seen || (busy && !stop_seen));
        if (reset || start_seen) begin
            bit_cnt  <= 4'h0;
            byte_idx <= 2'h0;
            rw       <= 1'h0;
            matched  <= 1'h0;
        end else if (scl_rise) begin
            shift   <= {shift[6:0], sda};
            bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
            if (bit_cnt == 4'h8 && byte_idx != 2'h3) begin
                byte_idx <= byte_idx + 2'h1;
            end
            if (byte_idx == 2'h0 && bit_cnt == 4'h7) begin
                rw      <= sda;
                matched <= shift[6:0] == tsc_pkg::SLAVE_ADDR;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_idle_scl; !busy |-> scl; endproperty
    a_idle_scl: assert property (p_idle_scl) else $error("scl low while bus idle");
    property p_idle_slave; !busy |-> !s_sda_oe; endproperty
    a_idle_slave: assert property (p_idle_slave) else $error("tuner drives sda while idle");
    property p_slave_stable; scl && prev_scl |-> $stable(s_sda_oe); endproperty
    a_slave_stable: assert property (p_slave_stable) else $error("tuner moved sda with scl high");
    property p_master_ctrl; scl && prev_scl && $changed(m_sda_oe) |-> ($rose(m_sda_oe) ? !busy : busy); endproperty
    a_master_ctrl: assert property (p_master_ctrl) else $error("sda edge under scl high is no start or stop");
    property p_addr_ack; ack_rise && byte_idx == 2'h0 && matched |-> s_sda_oe && !sda; endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address byte not acknowledged");
    property p_write_ack; ack_rise && byte_idx != 2'h0 && !rw && matched |-> s_sda_oe && !sda; endproperty
    a_write_ack: assert property (p_write_ack) else $error("written byte not acknowledged");
    property p_read_release; ack_rise && byte_idx != 2'h0 && rw |-> !s_sda_oe; endproperty
    a_read_release: assert property (p_read_release) else $error("tuner holds sda in master ack slot");
    property p_drive_slot;
        s_sda_oe && (byte_idx == 2'h0 || !rw) |-> bit_cnt == 4'h8 || (bit_cnt == 4'h0 && byte_idx != 2'h0);
    endproperty
    a_drive_slot: assert property (p_drive_slot) else $error("tuner drives sda outside ack slot");
    property p_ack_release; $fell(scl) && bit_cnt == 4'h0 && byte_idx != 2'h0 && !rw |-> ##[1:6] !s_sda_oe; endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack held past its clock");

    c_write_burst: cover property (ack_rise && byte_idx == 2'h3 && !rw);
    c_read_byte: cover property (ack_rise && byte_idx == 2'h2 && rw);
    c_stop: cover property (stop_seen);
endmodule
`default_nettype wire

// [test/tuner_serial_control_slave_tb_top.sv]
// self-checking bench: master end writes bursts to and reads status from the tuner end
`timescale 1ns/1ns
`default_nettype none
`define CHECK(what, exp, got) \
    comparisons++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("wrong value %s expected %h seen %h", what, exp, got); \
    end
module tuner_serial_control_slave_tb_top;
    logic        clk_sys;
    logic        reset;
    logic        cmd_valid;
    logic        cmd_read;
    logic        auto_band_select;
    logic [7:0]  cmd_reg;
    logic [7:0]  wr_byte;
    logic [7:0]  status_byte1_in;
    logic [3:0]  cmd_count;
    logic [1:0]  manual_oscillator;
    logic [1:0]  auto_oscillator;
    logic [2:0]  manual_subband;
    logic [2:0]  auto_subband;
    logic [2:0]  tuning_voltage;
    wire logic   cmd_ready, wr_take, rd_valid, done, nack_error, wr_valid, power_cycled_flag;
    wire logic [7:0] rd_byte, wr_addr, wr_data;
    logic [7:0]  wdata [16];
    logic [15:0] wq [$];
    logic [7:0]  rq [$];
    logic [7:0]  exp1;
    logic [7:0]  exp2;
    int          mismatches;
    int          comparisons;

    tsc_if bus_if ();
    // a quarter of 4 clocks gives the 160 ns link period
    tsc_master #(.QUARTER(4)) tsc_master_inst (.clk_sys(clk_sys), .reset(reset), .bus(bus_if.host),
        .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_reg(cmd_reg), .cmd_count(cmd_count), .wr_byte(wr_byte),
        .cmd_ready(cmd_ready), .wr_take(wr_take), .rd_valid(rd_valid), .rd_byte(rd_byte), .done(done),
        .nack_error(nack_error));
    tsc_slave tsc_slave_inst (.clk_sys(clk_sys), .reset(reset), .bus(bus_if.device),
        .auto_band_select(auto_band_select), .manual_oscillator(manual_oscillator),
        .manual_subband(manual_subband), .auto_oscillator(auto_oscillator), .auto_subband(auto_subband),
        .tuning_voltage(tuning_voltage), .status_byte1_in(status_byte1_in), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data), .power_cycled_flag(power_cycled_flag));
    tsc_asserts tsc_asserts_inst (.clk_sys(clk_sys), .reset(reset), .scl(bus_if.scl), .sda(bus_if.sda),
        .m_sda_oe(bus_if.m_sda_oe), .s_sda_oe(bus_if.s_sda_oe));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // collect every register write handed out and every byte the master receives
    always @(posedge clk_sys) begin
        if (wr_valid === 1'b1) begin
            wq.push_back({wr_addr, wr_data});
        end
        if (rd_valid === 1'b1) begin
            rq.push_back(rd_byte);
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one command through the master; the next write byte is offered right after each take
    task automatic run_cmd(input logic rd, input logic [7:0] start, input logic [3:0] cnt);
        int   idx;
        logic got_done;
        idx      = 0;
        got_done = 1'b0;
        wq.delete();
        rq.delete();
        @(negedge clk_sys);
        cmd_read  = rd;
        cmd_reg   = start;
        cmd_count = cnt;
        wr_byte   = wdata[0];
        cmd_valid = 1'b1;
        do @(posedge clk_sys); while (cmd_ready !== 1'b1);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        repeat (4000) begin
            @(posedge clk_sys);
            if (done === 1'b1) begin
                got_done = 1'b1;
                break;
            end
            if (wr_take === 1'b1) begin
                idx++;
                @(negedge clk_sys);
                wr_byte = wdata[idx % 16];
            end
        end
        // the tuner sees the stop only through its two-flop synchroniser, so give the flag time to settle
        repeat (4) @(negedge clk_sys);
        `CHECK("command finished", 1'b1, got_done)
        `CHECK("nack flag", 1'b0, nack_error)
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        mismatches++;
        print_verdict();
    end

    initial begin
        logic [7:0] burst_start [2];
        logic [3:0] burst_len [2];
        burst_start = '{8'h00, 8'hf8};
        burst_len   = '{4'h3, 4'hf};
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_reg = 8'h00;
        cmd_count = 4'h0;
        wr_byte = 8'h00;
        auto_band_select = 1'b0;
        manual_oscillator = 2'h1;
        manual_subband = 3'h6;
        auto_oscillator = 2'h2;
        auto_subband = 3'h5;
        tuning_voltage = 3'h4;
        status_byte1_in = 8'ha1;
        mismatches = 0;
        comparisons = 0;
        for (int i = 0; i < 16; i++) wdata[i] = 8'(i * 8'h35 + 8'h0e);
        repeat (16) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        `CHECK("idle scl", 1'b1, bus_if.scl)
        `CHECK("idle sda", 1'b1, bus_if.sda)
        `CHECK("power flag after reset", 1'b1, power_cycled_flag)
        // short burst, then a long one that runs across the top of the register space
        for (int b = 0; b < 2; b++) begin
            run_cmd(1'b0, burst_start[b], burst_len[b]);
            `CHECK("write count", 32'(burst_len[b]), wq.size())
            foreach (wq[i]) begin
                `CHECK("write addr and data", {8'(burst_start[b] + 8'(i)), wdata[i]}, wq[i])
            end
        end
        `CHECK("power flag kept by writes", 1'b1, power_cycled_flag)
        // auto selection with flag set, then manual with flag cleared and four bytes to wrap
        for (int m = 0; m < 2; m++) begin
            @(negedge clk_sys);
            auto_band_select = (m == 0);
            tuning_voltage   = m ? 3'h3 : 3'h4;
            status_byte1_in  = m ? 8'h5e : 8'ha1;
            exp1 = (status_byte1_in & ~tsc_pkg::PWR_MASK) | (m == 0 ? tsc_pkg::PWR_MASK : 8'h00);
            exp2 = m ? {manual_oscillator, manual_subband, tuning_voltage} : {auto_oscillator, auto_subband, tuning_voltage};
            run_cmd(1'b1, 8'h00, m ? 4'h4 : 4'h2);
            `CHECK("read count", m ? 4 : 2, rq.size())
            `CHECK("oscillator", exp2[7:6], rq[1][7:6])
            `CHECK("subband", exp2[5:3], rq[1][5:3])
            `CHECK("tuning voltage", exp2[2:0], rq[1][2:0])
            foreach (rq[i]) begin
                `CHECK("status byte", (i % 2) ? exp2 : exp1, rq[i])
            end
            `CHECK("power flag after read", 1'b0, power_cycled_flag)
        end
        print_verdict();
    end
endmodule
`default_nettype wire
